/* dv/dbf_cpu_model.sv */
// cpu side partner: issues array reads and program accesses on the request port
module dbf_cpu_model
   import dbf_pkg::*;
(
   input  wire logic         i_clk,
   output dbf_cpu_req_t      o_req,
   input  wire dbf_cpu_rsp_t i_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_req = '0;
   // reads and program commands share one path, from flash or ram code alike
   task automatic xfer(input logic w, input logic b, input logic [23:0] a, input logic [15:0] d,
                       input int gap, output logic [15:0] q, output logic ok);
      int n;
      repeat (gap) @(posedge i_clk);
      @(posedge i_clk);
      o_req <= '{valid: 1'b1, write: w, byte_sel: b, addr: a, wdata: d};
      @(posedge i_clk);
      // released fields carry the inverse so a stale address never looks held
      o_req <= '{valid: 1'b0, write: ~w, byte_sel: ~b, addr: ~a, wdata: ~d};
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_rsp.ack !== 1'b1 && n < 20);
      q = i_rsp.rdata;
      ok = (i_rsp.ack === 1'b1);
   endtask : xfer
endmodule : dbf_cpu_model

/* dv/dbf_top_assertions.sv */
// checker: port-level properties of the dual bank flash interface
module dbf_chk
   import dbf_pkg::*;
(
   // clock and reset
   input wire logic         I_MCLK,
   input wire logic         I_RST_N,
   // apb
   input wire logic         I_PSEL,
   input wire logic         I_PENABLE,
   input wire logic         I_PWRITE,
   input wire logic [11:0]  I_PADDR,
   input wire logic [31:0]  O_PRDATA,
   input wire logic         O_PREADY,
   input wire logic         O_PSLVERR,
   // array port and interrupt
   input wire dbf_cpu_req_t I_CPU_REQ,
   input wire dbf_cpu_rsp_t O_CPU_RSP,
   input wire logic         O_IRQ
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   logic irq_wr;
   logic unmapped_rd;
   assign irq_wr = I_PSEL && I_PENABLE && I_PWRITE &&
                   (I_PADDR == OFS_IRQ_STATUS || I_PADDR == OFS_IRQ_MASK);
   assign unmapped_rd = I_CPU_REQ.valid && !I_CPU_REQ.write &&
                        I_CPU_REQ.addr[23:16] != CPU_BANK_PREFIX &&
                        I_CPU_REQ.addr[23:16] != WRITER_PREFIX;
   a_ack_after_req: assert property (O_CPU_RSP.ack |-> $past(I_CPU_REQ.valid, 2))
      else $error("array answer without a request two cycles before");
   a_ack_single: assert property (O_CPU_RSP.ack |=> !O_CPU_RSP.ack)
      else $error("array answer longer than one cycle");
   a_rdata_hold: assert property (!O_CPU_RSP.ack |-> $stable(O_CPU_RSP.rdata))
      else $error("array read data moved without an answer");
   a_unmapped_zero: assert property (O_CPU_RSP.ack && $past(unmapped_rd, 2)
      |-> O_CPU_RSP.rdata == 16'h0000)
      else $error("read outside the array returned data");
   a_ready_access: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
      else $error("register access phase not answered");
   a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
      else $error("register ready longer than one cycle");
   a_err_unmapped: assert property (I_PSEL && !I_PENABLE && I_PADDR > OFS_IRQ_MASK
      |=> O_PSLVERR && O_PRDATA == 32'h0000_0000)
      else $error("unmapped register offset not refused");
   a_irq_clear: assert property ($fell(O_IRQ) |-> $past(irq_wr) || $past(irq_wr, 2))
      else $error("interrupt dropped without a software clear");
   c_ack: cover property (O_CPU_RSP.ack);
   c_irq: cover property ($rose(O_IRQ));
   c_err: cover property (O_PSLVERR);
endmodule : dbf_chk

bind dbf_top dbf_chk chk_u (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CPU_REQ(I_CPU_REQ),
   .O_CPU_RSP(O_CPU_RSP), .O_IRQ(O_IRQ));

/* dv/dual_bank_flash_interface_tb.sv */
// testbench of the dual bank flash interface with a reference model of the array
module dual_bank_flash_interface_tb;
   import dbf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic wr_mode = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, perr, ok;
   dbf_cpu_req_t cpu_req;
   dbf_cpu_rsp_t cpu_rsp;
   logic [15:0] q, s1, d;
   logic [15:0] mem [int];
   logic [23:0] pts [4] = '{24'hFF_3FFE, 24'hFF_4000, 24'hFF_7FFE, 24'hFF_8000};
   int err_count = 0;
   int comparisons = 0;
   int seed = 32'h81c3;

   always #10 clk = ~clk;

   dbf_top dut_u (.I_MCLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CPU_REQ(cpu_req),
      .O_CPU_RSP(cpu_rsp), .I_WRITER_MODE(wr_mode), .O_IRQ(irq));
   dbf_cpu_model cpu_u (.i_clk(clk), .o_req(cpu_req), .i_rsp(cpu_rsp));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dd;
      @(posedge clk);
      penable <= 1'b1;
      // no own limit: only the watchdog ends a wait for ready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [15:0] expv(input logic [23:0] a);
      return mem.exists(int'(a[15:1])) ? mem[int'(a[15:1])] : 16'hFFFF;
   endfunction : expv
   task automatic cpu(input logic w, input logic b, input logic [23:0] a, input logic [15:0] dd);
      cpu_u.xfer(w, b, a, dd, $random(seed) & 3, q, ok);
      chk("cpu answer", 1, ok);
   endtask : cpu
   task automatic rdchk(input logic [23:0] a);
      cpu(1'b0, 1'b0, a, 16'h0000);
      chk("array read", expv(a), q);
   endtask : rdchk
   // program is an and: bits only clear, a byte leaves its neighbour alone
   task automatic prog(input logic [23:0] a, input logic [15:0] dd, input logic b);
      cpu(1'b1, b, a, dd);
      if (b) mem[int'(a[15:1])] = expv(a) & (a[0] ? {dd[7:0], 8'hFF} : {8'hFF, dd[7:0]});
      else mem[int'(a[15:1])] = expv(a) & dd;
   endtask : prog
   task automatic wait_done(input logic [1:0] bits);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      chk("irq raised", 1, irq);
      apb(1'b0, OFS_IRQ_STATUS, 0);
      chk("irq status", {30'h0, bits}, rd);
      apb(1'b1, OFS_IRQ_STATUS, {30'h0, bits});
      repeat (3) @(posedge clk);
      chk("irq cleared", 0, irq);
   endtask : wait_done
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      // two array walks of 32768 cycles plus programs and polling, about 70k cycles
      #1_800_000;
      err_count++;
      $display("unexpected run length: expected end, seen timeout");
      complete_run();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(i * 4), 0);
         chk("reg reset", 0, rd);
         chk("reg refusal", i == 4, perr);
      end
      $display("test registers done");
      apb(1'b1, OFS_WRITE_CTRL, 32'h0000_13FF);
      cpu(1'b0, 1'b0, 24'hFF_0000, 0);
      s1 = q;
      cpu(1'b0, 1'b0, 24'hFF_0000, 0);
      chk("erase status", 0, {s1[15:7], s1[5:0]});
      chk("toggle", 1, s1[6] ^ q[6]);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk("busy flags", 32'h0000_001A, rd);
      rd = 0;
      for (int n = 0; n < 20000 && rd[1] !== 1'b1; n++) apb(1'b0, OFS_IRQ_STATUS, 0);
      chk("masked irq", 0, irq);
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
      repeat (20) @(posedge clk);
      chk("irq held", 1, irq);
      wait_done(2'b10);
      apb(1'b0, OFS_WRITE_CTRL, 0);
      chk("mask cleared", 0, rd);
      rdchk(24'hFF_FFFE);
      cpu(1'b1, 1'b0, 24'hFF_1000, 16'h0000);
      rdchk(24'hFF_1000);
      $display("test full erase done");
      apb(1'b1, OFS_CTRL_STATUS, 1);
      d = $random(seed);
      prog(24'hFF_1000, d, 1'b0);
      cpu(1'b0, 1'b0, 24'hFF_1000, 0);
      s1 = q;
      cpu(1'b0, 1'b0, 24'hFF_1000, 0);
      chk("status byte", 0, {s1[15:8], s1[5:0]});
      chk("poll bit", !d[7], s1[7]);
      chk("toggle", 1, s1[6] ^ q[6]);
      // code runs from the upper bank while the lower one programs
      rdchk(24'hFF_8000);
      wait_done(2'b01);
      rdchk(24'hFF_1000);
      d = $random(seed);
      prog(24'hFF_1001, d, 1'b1);
      wait_done(2'b01);
      rdchk(24'hFF_1000);
      cpu(1'b0, 1'b1, 24'hFF_1001, 0);
      chk("byte read", expv(24'hFF_1000) >> 8, q[7:0]);
      foreach (pts[i]) begin
         d = $random(seed);
         prog(pts[i], d, 1'b0);
         wait_done(2'b01);
      end
      $display("test program done");
      wr_mode <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk("writer flag", 1, rd[CS_WRITER_MODE]);
      cpu(1'b0, 1'b0, 24'h07_1000, 0);
      chk("writer read", expv(24'hFF_1000), q);
      cpu(1'b0, 1'b0, 24'hFF_1000, 0);
      chk("cpu view off", 0, q);
      wr_mode <= 1'b0;
      repeat (4) @(posedge clk);
      $display("test writer done");
      apb(1'b1, OFS_WRITE_CTRL, 32'h0000_1010);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk("erase upper bank", 32'h0000_0013, rd);
      repeat (50) @(posedge clk);
      apb(1'b1, OFS_WRITE_CTRL, 32'h0000_2000);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk("suspended", 32'h0000_0017, rd);
      rdchk(24'hFF_1000);
      rdchk(24'hFF_3FFE);
      cpu(1'b0, 1'b0, 24'hFF_4000, 0);
      chk("erasing sector", 0, {q[15:7], q[5:0]});
      apb(1'b1, OFS_WRITE_CTRL, 32'h0000_4000);
      foreach (mem[k]) if (k >= 'h2000 && k < 'h4000) mem[k] = 16'hFFFF;
      wait_done(2'b10);
      foreach (pts[i]) rdchk(pts[i]);
      rdchk(24'hFF_1000);
      $display("test sector erase done");
      complete_run();
   end
endmodule : dual_bank_flash_interface_tb

/* inc/dbf_pkg.sv */
// package: constants, field layouts and carrier types of the dual bank flash interface
package dbf_pkg;

   // address map of the array as seen by the cpu and by an external writer
   localparam logic [7:0]  CPU_BANK_PREFIX = 8'hFF;
   localparam logic [7:0]  WRITER_PREFIX   = 8'h07;
   localparam int          WORD_AW         = 15;
   localparam int          WORDS           = 32768;
   localparam logic [14:0] LAST_WORD       = 15'h7FFF;
   localparam int          SECTORS         = 10;

   // sector boundaries (offset within the bank)
   localparam logic [15:0] SEC4_BASE       = 16'h4000;
   localparam logic [15:0] SEC5_BASE       = 16'h8000;
   localparam logic [15:0] SEC6_BASE       = 16'hC000;

   // timing
   localparam int          READ_CYC        = 2;
   localparam logic [7:0]  PROG_CYC        = 8'h10;

   // apb register offsets
   localparam logic [11:0] OFS_CTRL_STATUS = 12'h000;
   localparam logic [11:0] OFS_WRITE_CTRL  = 12'h004;
   localparam logic [11:0] OFS_IRQ_STATUS  = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK    = 12'h00C;

   // flash_control_status fields
   localparam int          CS_PROG_EN      = 0;
   localparam int          CS_BUSY         = 1;
   localparam int          CS_SUSPENDED    = 2;
   localparam int          CS_LOWER_BUSY   = 3;
   localparam int          CS_UPPER_BUSY   = 4;
   localparam int          CS_WRITER_MODE  = 5;

   // flash_write_control_status fields
   localparam int          WC_START_ERASE  = 12;
   localparam int          WC_SUSPEND      = 13;
   localparam int          WC_RESUME       = 14;

   // interrupt status / mask fields
   localparam int          IRQ_PROG_DONE   = 0;
   localparam int          IRQ_ERASE_DONE  = 1;

   // reset values
   localparam logic [9:0]  RST_ERASE_MASK  = 10'h000;
   localparam logic [1:0]  RST_IRQ         = 2'h0;

   // status word fields returned from a bank that is busy
   localparam int          ST_POLL         = 7;
   localparam int          ST_TOGGLE       = 6;

   typedef enum logic [0:0] {CPU_IDLE, CPU_ACC}          dbf_cpu_st_t;
   typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} dbf_op_st_t;

   // one access from the cpu (or from the writer interface logic)
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        byte_sel;
      logic [23:0] addr;
      logic [15:0] wdata;
   } dbf_cpu_req_t;

   // answer of the array port
   typedef struct packed {
      logic        ack;
      logic [15:0] rdata;
   } dbf_cpu_rsp_t;

endpackage : dbf_pkg

/* verilog/dbf_top.sv */
// dual bank flash interface: array, sector decode, program/erase sequencer, apb registers
// Notes on behaviour
// - array occupies the top 64 KB bank, FF0000 to FFFFFF
// - byte or halfword access; sectors small x4, large x2, small x4
// - ten sectors decoded at 4 KB / 16 KB boundaries 4000, 8000, C000
// - program or erase in one bank while the other bank serves reads
// - erase may be suspended and resumed; other sectors readable meanwhile
// - busy bank returns polling and toggle bits, data when finished
// - completion of program or erase can raise the cpu interrupt
// - erase acts on any chosen set of sectors
// - an array read takes at least two clock cycles
// - no manufacturer or device code read mode exists
// - writer addresses use base 70000 in place of FF0000, one to one
// - parallel writer, serial writer and cpu software may all program
// - cpu may read and issue program accesses through this port
// - commands accepted from code in flash or in ram alike
module dbf_top (
   // clock, reset, enable
   input  wire  logic                 I_MCLK,
   input  wire  logic                 I_RST_N,
   input  wire  logic                 I_CE,
   // apb slave
   input  wire  logic                 I_PSEL,
   input  wire  logic                 I_PENABLE,
   input  wire  logic                 I_PWRITE,
   input  wire  logic [11:0]          I_PADDR,
   input  wire  logic [31:0]          I_PWDATA,
   output logic       [31:0]          O_PRDATA,
   output logic                       O_PREADY,
   output logic                       O_PSLVERR,
   // array access port
   input  wire  dbf_pkg::dbf_cpu_req_t I_CPU_REQ,
   output dbf_pkg::dbf_cpu_rsp_t       O_CPU_RSP,
   // writer mode pin, asynchronous
   input  wire  logic                 I_WRITER_MODE,
   // interrupt
   output logic                       O_IRQ
);
   import dbf_pkg::*;

   typedef struct packed {
      logic         wr_meta;
      logic         wr_sync;
      dbf_cpu_st_t  cpu_st;
      logic [14:0]  cpu_addr;
      logic         cpu_hit;
      logic         cpu_byte;
      logic         cpu_hi;
      logic         ack;
      logic [15:0]  rdata;
      dbf_op_st_t   op_st;
      logic [14:0]  prog_addr;
      logic [15:0]  prog_data;
      logic         prog_poll;
      logic [7:0]   cnt;
      logic [14:0]  erase_addr;
      logic [9:0]   erase_mask;
      logic         suspended;
      logic         toggle;
      logic         prog_en;
      logic [1:0]   sts;
      logic [1:0]   msk;
      logic         irq;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
   } dbf_state_t;

   dbf_state_t s_r;
   dbf_state_t s_nxt;

   logic        rst_meta_r;
   logic        rst_sync_r;
   logic [15:0] mem [0:WORDS-1];
   logic        mem_we;
   logic        mem_and;
   logic [14:0] mem_wa;
   logic [15:0] mem_wd;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // sector number of a byte offset within the bank
   function automatic logic [3:0] sector_of(input logic [15:0] ofs);
      logic [3:0] sec;
      sec = 4'd0;
      if (ofs < SEC4_BASE) begin
         sec = {2'b00, ofs[13:12]};
      end else if (ofs < SEC5_BASE) begin
         sec = 4'd4;
      end else if (ofs < SEC6_BASE) begin
         sec = 4'd5;
      end else begin
         sec = 4'd6 + {2'b00, ofs[13:12]};
      end
      return sec;
   endfunction : sector_of

   // bank of a byte offset: the lower bank ends where the first large sector begins
   function automatic logic bank_of(input logic [15:0] ofs);
      return (ofs >= SEC4_BASE);
   endfunction : bank_of

   logic [1:0]  bank_busy;
   logic [15:0] req_ofs;
   logic        req_hit;
   logic [3:0]  rd_sec;
   logic        rd_busy;
   logic [15:0] rd_word;
   logic [7:0]  st_byte;
   logic        apb_setup;
   logic        apb_wr;
   logic [3:0]  er_sec;
   logic [15:0] pd;
   logic [1:0]  sts_set;

   always_comb begin
      s_nxt     = s_r;
      sts_set   = '0;
      mem_we    = 1'b0;
      mem_and   = 1'b0;
      mem_wa    = '0;
      mem_wd    = '0;
      pd        = '0;
      er_sec    = '0;

      s_nxt.wr_meta = I_WRITER_MODE;
      s_nxt.wr_sync = s_r.wr_meta;

      // banks tied up by the operation in flight
      bank_busy = 2'b00;
      if (s_r.op_st == OP_PROG) begin
         bank_busy[bank_of({s_r.prog_addr, 1'b0})] = 1'b1;
      end else if (s_r.op_st == OP_ERASE) begin
         bank_busy[0] = |s_r.erase_mask[3:0];
         bank_busy[1] = |s_r.erase_mask[9:4];
      end

      // address decode: cpu view or writer view, same offset
      req_ofs = I_CPU_REQ.addr[15:0];
      if (s_r.wr_sync) begin
         req_hit = (I_CPU_REQ.addr[23:16] == WRITER_PREFIX);
      end else begin
         req_hit = (I_CPU_REQ.addr[23:16] == CPU_BANK_PREFIX);
      end

      // ---------------- array access port ----------------
      s_nxt.ack = 1'b0;
      rd_sec  = sector_of({s_r.cpu_addr, 1'b0});
      rd_busy = bank_busy[bank_of({s_r.cpu_addr, 1'b0})] &&
                !(s_r.suspended && !s_r.erase_mask[rd_sec]);
      rd_word = mem[s_r.cpu_addr];
      st_byte = '0;
      st_byte[ST_POLL]   = (s_r.op_st == OP_PROG) ? ~s_r.prog_poll : 1'b0;
      st_byte[ST_TOGGLE] = s_r.toggle;
      case (s_r.cpu_st)
         CPU_IDLE: begin
            if (I_CPU_REQ.valid) begin
               s_nxt.cpu_st   = CPU_ACC;
               s_nxt.cpu_addr = req_ofs[15:1];
               s_nxt.cpu_hit  = req_hit;
               s_nxt.cpu_byte = I_CPU_REQ.byte_sel;
               s_nxt.cpu_hi   = I_CPU_REQ.byte_sel & req_ofs[0];
               // a program access only starts on an idle sequencer
               if (I_CPU_REQ.write && req_hit && s_r.prog_en && s_r.op_st == OP_IDLE) begin
                  pd = I_CPU_REQ.wdata;
                  if (I_CPU_REQ.byte_sel) begin
                     pd = req_ofs[0] ? {I_CPU_REQ.wdata[7:0], 8'hFF}
                                     : {8'hFF, I_CPU_REQ.wdata[7:0]};
                  end
                  s_nxt.op_st     = OP_PROG;
                  s_nxt.prog_addr = req_ofs[15:1];
                  s_nxt.prog_data = pd;
                  s_nxt.prog_poll = (I_CPU_REQ.byte_sel && req_ofs[0]) ? pd[15] : pd[7];
                  s_nxt.cnt       = PROG_CYC - 8'h01;
                  s_nxt.toggle    = 1'b0;
               end
            end
         end
         CPU_ACC: begin
            // second cycle of the access: answer appears at the next edge
            s_nxt.cpu_st = CPU_IDLE;
            s_nxt.ack    = 1'b1;
            if (!s_r.cpu_hit) begin
               s_nxt.rdata = '0;
            end else if (rd_busy) begin
               s_nxt.rdata  = {8'h00, st_byte};
               s_nxt.toggle = ~s_r.toggle;
            end else if (s_r.cpu_byte) begin
               s_nxt.rdata = {8'h00, s_r.cpu_hi ? rd_word[15:8] : rd_word[7:0]};
            end else begin
               s_nxt.rdata = rd_word;
            end
         end
         default: s_nxt.cpu_st = CPU_IDLE;
      endcase

      // ---------------- program / erase sequencer ----------------
      case (s_r.op_st)
         OP_IDLE: begin
            s_nxt.suspended = 1'b0;
         end
         OP_PROG: begin
            if (s_r.cnt == 8'h00) begin
               mem_we  = 1'b1;
               mem_and = 1'b1;                                    // bits only go 1 -> 0
               mem_wa  = s_r.prog_addr;
               mem_wd  = s_r.prog_data;
               s_nxt.op_st = OP_IDLE;
               s_nxt.sts[IRQ_PROG_DONE] = 1'b1;
               sts_set[IRQ_PROG_DONE]   = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - 8'h01;
            end
         end
         OP_ERASE: begin
            // one word per cycle walks the whole array; words of unselected sectors are passed without a write
            if (!s_r.suspended) begin
               er_sec = sector_of({s_r.erase_addr, 1'b0});
               if (s_r.erase_mask[er_sec]) begin
                  mem_we = 1'b1;
                  mem_wa = s_r.erase_addr;
                  mem_wd = 16'hFFFF;
               end
               s_nxt.erase_addr = s_r.erase_addr + 15'h0001;
               if (s_r.erase_addr == LAST_WORD) begin
                  s_nxt.op_st      = OP_IDLE;
                  s_nxt.erase_mask = RST_ERASE_MASK;
                  s_nxt.sts[IRQ_ERASE_DONE] = 1'b1;
                  sts_set[IRQ_ERASE_DONE]   = 1'b1;
               end
            end
         end
         default: s_nxt.op_st = OP_IDLE;
      endcase

      // ---------------- apb slave ----------------
      apb_setup = I_PSEL && !I_PENABLE;
      apb_wr    = I_PSEL && I_PENABLE && s_r.pready && I_PWRITE;
      s_nxt.pready  = apb_setup;
      s_nxt.pslverr = 1'b0;
      if (apb_setup) begin
         s_nxt.prdata = '0;
         case (I_PADDR)
            OFS_CTRL_STATUS: begin
               s_nxt.prdata[CS_PROG_EN]     = s_r.prog_en;
               s_nxt.prdata[CS_BUSY]        = (s_r.op_st != OP_IDLE);
               s_nxt.prdata[CS_SUSPENDED]   = s_r.suspended;
               s_nxt.prdata[CS_LOWER_BUSY]  = bank_busy[0];
               s_nxt.prdata[CS_UPPER_BUSY]  = bank_busy[1];
               s_nxt.prdata[CS_WRITER_MODE] = s_r.wr_sync;
            end
            OFS_WRITE_CTRL:  s_nxt.prdata[SECTORS-1:0] = s_r.erase_mask;
            OFS_IRQ_STATUS:  s_nxt.prdata[1:0] = s_r.sts;
            OFS_IRQ_MASK:    s_nxt.prdata[1:0] = s_r.msk;
            default:         s_nxt.pslverr = 1'b1;
         endcase
      end
      if (apb_wr) begin
         case (I_PADDR)
            OFS_CTRL_STATUS: s_nxt.prog_en = I_PWDATA[CS_PROG_EN];
            OFS_WRITE_CTRL: begin
               if (I_PWDATA[WC_START_ERASE] && s_r.op_st == OP_IDLE &&
                   |I_PWDATA[SECTORS-1:0]) begin
                  s_nxt.op_st      = OP_ERASE;
                  s_nxt.erase_mask = I_PWDATA[SECTORS-1:0];
                  s_nxt.erase_addr = '0;
                  s_nxt.toggle     = 1'b0;
               end
               if (I_PWDATA[WC_SUSPEND] && s_r.op_st == OP_ERASE) begin
                  s_nxt.suspended = 1'b1;
               end
               if (I_PWDATA[WC_RESUME] && s_r.op_st == OP_ERASE) begin
                  s_nxt.suspended = 1'b0;
               end
            end
            // clear by writing one; a completion in the same cycle wins
            OFS_IRQ_STATUS:  s_nxt.sts = (s_r.sts & ~I_PWDATA[1:0]) | sts_set;
            OFS_IRQ_MASK:    s_nxt.msk = I_PWDATA[1:0];
            default: ;
         endcase
      end
      s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
   end

   // array has no identification read path: a read returns data or status, or zero outside the array
   always_ff @(posedge I_MCLK) begin
      if (I_CE && rst_sync_r && mem_we) begin
         mem[mem_wa] <= mem_and ? (mem[mem_wa] & mem_wd) : mem_wd;
      end
   end

   always_ff @(posedge I_MCLK or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         s_r            <= '0;
         s_r.cpu_st     <= CPU_IDLE;
         s_r.op_st      <= OP_IDLE;
         s_r.erase_mask <= RST_ERASE_MASK;
         s_r.sts        <= RST_IRQ;
         s_r.msk        <= RST_IRQ;
      end else if (I_CE) begin
         s_r <= s_nxt;
      end
   end

   assign O_PRDATA        = s_r.prdata;
   assign O_PREADY        = s_r.pready;
   assign O_PSLVERR       = s_r.pslverr;
   assign O_CPU_RSP.ack   = s_r.ack;
   assign O_CPU_RSP.rdata = s_r.rdata;
   assign O_IRQ           = s_r.irq;

endmodule : dbf_top
